/* rtl/lsg_pkg.sv */
package lsg_pkg;
  localparam int unsigned LSG_ADDR_W = 6;
  localparam int unsigned LSG_DATA_W = 32;
  localparam int unsigned LSG_P6_W   = 8;
  localparam int unsigned LSG_P9_W   = 4;

  localparam logic [5:0] LSG_OFF_P6_DATA   = 6'h00;
  localparam logic [5:0] LSG_OFF_P6_DIR    = 6'h04;
  localparam logic [5:0] LSG_OFF_P9_DATA   = 6'h08;
  localparam logic [5:0] LSG_OFF_P9_DIR    = 6'h0c;
  localparam logic [5:0] LSG_OFF_LCD_EN1   = 6'h10;
  localparam logic [5:0] LSG_OFF_LCD_EN3   = 6'h14;
  localparam logic [5:0] LSG_OFF_LCD_EN4   = 6'h18;
  localparam logic [5:0] LSG_OFF_STANDBY   = 6'h1c;
  localparam logic [5:0] LSG_OFF_P6_LATCH  = 6'h20;
  localparam logic [5:0] LSG_OFF_P9_LATCH  = 6'h24;

  // lcd_enable_reg1 fields
  localparam int unsigned LSG_EN1_INCTL_BIT  = 0;
  localparam int unsigned LSG_EN1_SUPPLY_LSB = 1;
  // lcd_enable_reg3 holds segment selects of port6 bits 1:0 here
  localparam int unsigned LSG_EN3_SEG_LSB   = 6;
  localparam int unsigned LSG_EN3_SEG_W     = 2;
  // lcd_enable_reg4 holds segment selects of port6 bits 7:2 here
  localparam int unsigned LSG_EN4_SEG_LSB   = 0;
  localparam int unsigned LSG_EN4_SEG_W     = 6;
  localparam int unsigned LSG_STBY_HIZ_BIT  = 0;

  localparam logic [7:0] LSG_RST_LATCH   = 8'h00;
  localparam logic [7:0] LSG_RST_DIR     = 8'h00;
  localparam logic [7:0] LSG_RST_LCD_EN  = 8'h00;
  localparam logic [7:0] LSG_RST_STANDBY = 8'h00;

  localparam logic [1:0] LSG_RESP_OKAY   = 2'b00;
  localparam logic [1:0] LSG_RESP_SLVERR = 2'b10;
endpackage

/* rtl/lsg_port_slice.sv */
`timescale 1ns/1ps
`default_nettype none
module lsg_port_slice #(
  parameter int unsigned W = 8
) (
  input  wire logic [W-1:0] latch,
  input  wire logic [W-1:0] dir,
  input  wire logic [W-1:0] alt_sel,
  input  wire logic [W-1:0] alt_drive,
  input  wire logic [W-1:0] alt_level,
  input  wire logic [W-1:0] in_en,
  input  wire logic         hiz,
  input  wire logic [W-1:0] pin_i,
  output logic      [W-1:0] pin_o,
  output logic      [W-1:0] pin_oe,
  output logic      [W-1:0] in_level
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_comb begin
        if (hiz) begin
          pin_oe[i] = 1'b0;
          pin_o[i]  = 1'b0;
        end else if (alt_sel[i]) begin
          // lcd owns the pin; the gpio driver is never enabled here
          pin_oe[i] = alt_drive[i];
          pin_o[i]  = alt_level[i];
        end else begin
          pin_oe[i] = dir[i];
          pin_o[i]  = latch[i];
        end
      end
      // blocked inputs read low so a floating pad cannot leak
      assign in_level[i] = pin_i[i] & in_en[i] & ~hiz;
    end
  endgenerate
endmodule
`default_nettype wire

/* rtl/lsg_gpio_top.sv */
`timescale 1ns/1ps
`default_nettype none
module lsg_gpio_top
  import lsg_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [LSG_ADDR_W-1:0] awaddr,
  input  wire logic [2:0]            awprot,
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [LSG_DATA_W-1:0] wdata,
  input  wire logic [3:0]            wstrb,
  input  wire logic                  wvalid,
  output logic                       wready,
  output logic [1:0]                 bresp,
  output logic                       bvalid,
  input  wire logic                  bready,
  input  wire logic [LSG_ADDR_W-1:0] araddr,
  input  wire logic [2:0]            arprot,
  input  wire logic                  arvalid,
  output logic                       arready,
  output logic [LSG_DATA_W-1:0]      rdata,
  output logic [1:0]                 rresp,
  output logic                       rvalid,
  input  wire logic                  rready,
  input  wire logic                  standby_req,
  input  wire logic [LSG_P6_W-1:0]   port6_pin_i,
  output logic [LSG_P6_W-1:0]        port6_pin_o,
  output logic [LSG_P6_W-1:0]        port6_pin_oe,
  input  wire logic [LSG_P6_W-1:0]   lcd_seg_level,
  output logic [LSG_P6_W-1:0]        lcd_seg_en,
  input  wire logic [LSG_P9_W-1:0]   port9_pin_i,
  output logic [LSG_P9_W-1:0]        port9_pin_o,
  output logic [LSG_P9_W-1:0]        port9_pin_oe,
  output logic [LSG_P9_W-1:0]        lcd_supply_en
);
  logic [7:0]            port6_data_latch;
  logic [7:0]            port6_direction;
  logic [3:0]            port9_data_latch;
  logic [3:0]            port9_direction;
  logic [7:0]            lcd_enable_reg1;
  logic [7:0]            lcd_enable_reg3;
  logic [7:0]            lcd_enable_reg4;
  logic [7:0]            standby_control;
  logic                  aw_held;
  logic                  w_held;
  logic [LSG_ADDR_W-1:0] aw_addr_q;
  logic [7:0]            w_data_q;
  logic                  w_strb_q;
  logic [LSG_ADDR_W-1:0] wr_addr;
  logic [7:0]            wr_data;
  logic                  wr_strb;
  logic                  aw_take;
  logic                  w_take;
  logic                  do_write;
  logic                  wr_hit;
  logic                  rd_hit;
  logic [7:0]            rd_data;
  logic [LSG_P6_W-1:0]   port6_seg_sel;
  logic [LSG_P9_W-1:0]   port9_supply_sel;
  logic                  port_input_control;
  logic                  pins_hiz;
  logic [LSG_P6_W-1:0]   port6_in_level;
  logic [LSG_P9_W-1:0]   port9_in_level;
  logic [LSG_P6_W-1:0]   port6_sampled;
  logic [LSG_P9_W-1:0]   port9_sampled;
  logic [LSG_P6_W-1:0]   port6_in_en;
  logic [LSG_P9_W-1:0]   port9_in_en;
  logic [LSG_P6_W-1:0]   port6_read;
  logic [LSG_P9_W-1:0]   port9_read;
  logic [LSG_P6_W-1:0]   port6_pad_o;
  logic [LSG_P6_W-1:0]   port6_pad_oe;
  logic [LSG_P9_W-1:0]   port9_pad_o;
  logic [LSG_P9_W-1:0]   port9_pad_oe;
  logic [LSG_P6_W-1:0]   lcd_seg_on;
  logic [LSG_P9_W-1:0]   lcd_supply_on;

  // write channel: address and data are taken in either order
  assign awready  = ~aw_held & ~bvalid;
  assign wready   = ~w_held & ~bvalid;
  assign aw_take  = awvalid & awready;
  assign w_take   = wvalid & wready;
  assign wr_addr  = aw_held ? aw_addr_q : awaddr;
  assign wr_data  = w_held ? w_data_q : wdata[7:0];
  assign wr_strb  = w_held ? w_strb_q : wstrb[0];
  assign do_write = (aw_held | aw_take) & (w_held | w_take);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held   <= 1'b0;
      aw_addr_q <= '0;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end else if (aw_take) begin
      aw_held   <= 1'b1;
      aw_addr_q <= awaddr;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held   <= 1'b0;
      w_data_q <= 8'h00;
      w_strb_q <= 1'b0;
    end else if (do_write) begin
      w_held <= 1'b0;
    end else if (w_take) begin
      w_held   <= 1'b1;
      w_data_q <= wdata[7:0];
      w_strb_q <= wstrb[0];
    end
  end

  always_comb begin
    case ({wr_addr[LSG_ADDR_W-1:2], 2'b00})
      LSG_OFF_P6_DATA,
      LSG_OFF_P6_DIR,
      LSG_OFF_P9_DATA,
      LSG_OFF_P9_DIR,
      LSG_OFF_LCD_EN1,
      LSG_OFF_LCD_EN3,
      LSG_OFF_LCD_EN4,
      LSG_OFF_STANDBY,
      LSG_OFF_P6_LATCH,
      LSG_OFF_P9_LATCH: wr_hit = 1'b1;
      default:          wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= LSG_RESP_OKAY;
    end else if (do_write) begin
      bvalid <= 1'b1;
      bresp  <= wr_hit ? LSG_RESP_OKAY : LSG_RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // data latch loads on every write to its data offset with wstrb[0] set, regardless of direction
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port6_data_latch <= LSG_RST_LATCH;
      port9_data_latch <= LSG_RST_LATCH[3:0];
    end else if (do_write && wr_strb) begin
      case ({wr_addr[LSG_ADDR_W-1:2], 2'b00})
        LSG_OFF_P6_DATA: port6_data_latch <= wr_data;
        LSG_OFF_P9_DATA: port9_data_latch <= wr_data[3:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port6_direction <= LSG_RST_DIR;
      port9_direction <= LSG_RST_DIR[3:0];
    end else if (do_write && wr_strb) begin
      case ({wr_addr[LSG_ADDR_W-1:2], 2'b00})
        LSG_OFF_P6_DIR: port6_direction <= wr_data;
        LSG_OFF_P9_DIR: port9_direction <= wr_data[3:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lcd_enable_reg1 <= LSG_RST_LCD_EN;
      lcd_enable_reg3 <= LSG_RST_LCD_EN;
      lcd_enable_reg4 <= LSG_RST_LCD_EN;
      standby_control <= LSG_RST_STANDBY;
    end else if (do_write && wr_strb) begin
      case ({wr_addr[LSG_ADDR_W-1:2], 2'b00})
        LSG_OFF_LCD_EN1: lcd_enable_reg1 <= wr_data;
        LSG_OFF_LCD_EN3: lcd_enable_reg3 <= wr_data;
        LSG_OFF_LCD_EN4: lcd_enable_reg4 <= wr_data;
        LSG_OFF_STANDBY: standby_control <= wr_data;
        default: ;
      endcase
    end
  end

  // pin function selection
  assign port6_seg_sel = {lcd_enable_reg4[LSG_EN4_SEG_LSB +: LSG_EN4_SEG_W],
                          lcd_enable_reg3[LSG_EN3_SEG_LSB +: LSG_EN3_SEG_W]};
  assign port_input_control = lcd_enable_reg1[LSG_EN1_INCTL_BIT];
  assign lcd_supply_on = lcd_enable_reg1[LSG_EN1_SUPPLY_LSB +: LSG_P9_W];
  // supply inputs one..four sit on pins 3..0, so the field is reversed
  always_comb begin
    for (int k = 0; k < LSG_P9_W; k++) begin
      port9_supply_sel[LSG_P9_W-1-k] = lcd_supply_on[k];
    end
  end
  // segments only reach the pads once input control is set
  assign lcd_seg_on    = port6_seg_sel & {LSG_P6_W{port_input_control}};
  assign pins_hiz      = standby_req & standby_control[LSG_STBY_HIZ_BIT];

  // shared port6 inputs stay blocked until input control is set
  assign port6_in_en = {LSG_P6_W{port_input_control}};
  // supply pins are analog, so their digital input is blocked
  assign port9_in_en = ~port9_supply_sel;

  lsg_port_slice #(
    .W (LSG_P6_W)
  ) u_port6 (
    .latch     (port6_data_latch),
    .dir       (port6_direction),
    .alt_sel   (port6_seg_sel),
    .alt_drive (lcd_seg_on),
    .alt_level (lcd_seg_level),
    .in_en     (port6_in_en),
    .hiz       (pins_hiz),
    .pin_i     (port6_pin_i),
    .pin_o     (port6_pad_o),
    .pin_oe    (port6_pad_oe),
    .in_level  (port6_in_level)
  );

  lsg_port_slice #(
    .W (LSG_P9_W)
  ) u_port9 (
    .latch     (port9_data_latch),
    .dir       (port9_direction),
    .alt_sel   (port9_supply_sel),
    .alt_drive ({LSG_P9_W{1'b0}}),
    .alt_level ({LSG_P9_W{1'b0}}),
    .in_en     (port9_in_en),
    .hiz       (pins_hiz),
    .pin_i     (port9_pin_i),
    .pin_o     (port9_pad_o),
    .pin_oe    (port9_pad_oe),
    .in_level  (port9_in_level)
  );

  // pads switch from flops, so select-logic glitches never reach a pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port6_pin_o   <= '0;
      port6_pin_oe  <= '0;
      port9_pin_o   <= '0;
      port9_pin_oe  <= '0;
      lcd_seg_en    <= '0;
      lcd_supply_en <= '0;
    end else begin
      port6_pin_o   <= port6_pad_o;
      port6_pin_oe  <= port6_pad_oe;
      port9_pin_o   <= port9_pad_o;
      port9_pin_oe  <= port9_pad_oe;
      lcd_seg_en    <= lcd_seg_on;
      lcd_supply_en <= lcd_supply_on;
    end
  end

  // one flop on the input path keeps the read mux off the pads
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port6_sampled <= '0;
      port9_sampled <= '0;
    end else begin
      port6_sampled <= port6_in_level;
      port9_sampled <= port9_in_level;
    end
  end

  assign port6_read = (port6_direction & port6_data_latch) |
                      (~port6_direction & port6_sampled);
  assign port9_read = (port9_direction & port9_data_latch) |
                      (~port9_direction & port9_sampled);

  always_comb begin
    rd_hit  = 1'b1;
    rd_data = 8'h00;
    case ({araddr[LSG_ADDR_W-1:2], 2'b00})
      LSG_OFF_P6_DATA:  rd_data = port6_read;
      LSG_OFF_P6_DIR:   rd_data = port6_direction;
      LSG_OFF_P9_DATA:  rd_data = {4'h0, port9_read};
      LSG_OFF_P9_DIR:   rd_data = {4'h0, port9_direction};
      LSG_OFF_LCD_EN1:  rd_data = lcd_enable_reg1;
      LSG_OFF_LCD_EN3:  rd_data = lcd_enable_reg3;
      LSG_OFF_LCD_EN4:  rd_data = lcd_enable_reg4;
      LSG_OFF_STANDBY:  rd_data = standby_control;
      // latch views serve read-modify-write sequences
      LSG_OFF_P6_LATCH: rd_data = port6_data_latch;
      LSG_OFF_P9_LATCH: rd_data = {4'h0, port9_data_latch};
      default:          rd_hit  = 1'b0;
    endcase
  end

  assign arready = ~rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= LSG_RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= {24'h000000, rd_data};
      rresp  <= rd_hit ? LSG_RESP_OKAY : LSG_RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* test/lsg_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module lsg_checker
  import lsg_pkg::*;
(
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              awvalid,
  input wire logic              awready,
  input wire logic              wvalid,
  input wire logic              wready,
  input wire logic              bvalid,
  input wire logic              bready,
  input wire logic [1:0]        bresp,
  input wire logic              arvalid,
  input wire logic              arready,
  input wire logic              rvalid,
  input wire logic              rready,
  input wire logic              standby_req,
  input wire logic [LSG_P6_W-1:0] port6_pin_o,
  input wire logic [LSG_P6_W-1:0] port6_pin_oe,
  input wire logic [LSG_P6_W-1:0] lcd_seg_level,
  input wire logic [LSG_P6_W-1:0] lcd_seg_en,
  input wire logic [LSG_P9_W-1:0] port9_pin_oe,
  input wire logic [LSG_P9_W-1:0] lcd_supply_en
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_rst;
    disable iff (1'b0) !aresetn |=> port6_pin_oe == 8'h00 && port9_pin_oe == 4'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("pin driven after reset");
  // supply input k sits on pin 3-k, hence the reversed bits
  property p_sup;
    lcd_supply_en != 4'h0 |-> (port9_pin_oe & {lcd_supply_en[0], lcd_supply_en[1],
      lcd_supply_en[2], lcd_supply_en[3]}) == 4'h0;
  endproperty
  a_sup: assert property (p_sup) else $error("supply pin driven");
  // pads are registered, so they carry the previous cycle's segment level
  property p_seg;
    !$past(standby_req) && lcd_seg_en != 8'h00 |-> (lcd_seg_en & ~port6_pin_oe) == 8'h00
      && ((port6_pin_o ^ $past(lcd_seg_level)) & lcd_seg_en) == 8'h00;
  endproperty
  a_seg: assert property (p_seg) else $error("segment level not on pin");
  property p_b_lat;
    awvalid && awready && wvalid && wready && !bvalid |=> bvalid;
  endproperty
  a_b_lat: assert property (p_b_lat) else $error("write response late");
  property p_r_lat;
    arvalid && arready |=> rvalid;
  endproperty
  a_r_lat: assert property (p_r_lat) else $error("read data late");
  property p_b_done;
    bvalid && bready |=> !bvalid;
  endproperty
  a_b_done: assert property (p_b_done) else $error("write response repeated");
  property p_r_done;
    rvalid && rready |=> !rvalid;
  endproperty
  a_r_done: assert property (p_r_done) else $error("read data repeated");
  // pin setup may only move on a write (two edges back) or a standby change
  property p_oe_cause;
    !$stable(port6_pin_oe) |-> $past(awvalid && awready || wvalid && wready, 2)
      || $past(standby_req) != $past(standby_req, 2);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("pin enable moved alone");
  cover property (bvalid && bresp == LSG_RESP_SLVERR);
  cover property (lcd_seg_en != 8'h00 && !standby_req);
  cover property (standby_req && port6_pin_oe == 8'h00);
endmodule
bind lsg_gpio_top lsg_checker u_chk (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready,
  .bvalid, .bready, .bresp, .arvalid, .arready, .rvalid, .rready, .standby_req,
  .port6_pin_o, .port6_pin_oe, .lcd_seg_level, .lcd_seg_en, .port9_pin_oe, .lcd_supply_en);
`default_nettype wire

/* test/lsg_pin_model.sv */
`timescale 1ns/1ps
`default_nettype none
module lsg_pin_model (
  input wire logic       aclk,
  input wire logic [7:0] ext6,
  input wire logic [3:0] ext9,
  input wire logic [7:0] o6,
  input wire logic [7:0] oe6,
  input wire logic [3:0] o9,
  input wire logic [3:0] oe9,
  output logic     [7:0] pin6,
  output logic     [3:0] pin9,
  output var logic [7:0] seg_lvl = 8'h00
);
  // controller waveform moves every cycle so a stuck segment path shows
  always @(posedge aclk) begin
    seg_lvl <= seg_lvl + 8'h1b;
  end
  // an undriven pad follows the board level
  assign pin6 = (oe6 & o6) | (~oe6 & ext6);
  assign pin9 = (oe9 & o9) | (~oe9 & ext9);
endmodule
`default_nettype wire

/* test/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import lsg_pkg::*;
;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, standby_req;
  logic awready, wready, bvalid, arready, rvalid;
  logic [5:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rs;
  logic [3:0] wstrb, port9_pin_i, port9_pin_o, port9_pin_oe, lcd_supply_en, ext9;
  logic [1:0] bresp, rresp;
  logic [7:0] port6_pin_i, port6_pin_o, port6_pin_oe, lcd_seg_level, lcd_seg_en, ext6;
  int error_cnt, n_tests;
  lsg_gpio_top dut (.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .standby_req, .port6_pin_i, .port6_pin_o,
    .port6_pin_oe, .lcd_seg_level, .lcd_seg_en, .port9_pin_i, .port9_pin_o, .port9_pin_oe,
    .lcd_supply_en);
  lsg_pin_model u_pins (.aclk, .ext6, .ext9, .o6(port6_pin_o), .oe6(port6_pin_oe),
    .o9(port9_pin_o), .oe9(port9_pin_oe), .pin6(port6_pin_i), .pin9(port9_pin_i),
    .seg_lvl(lcd_seg_level));
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  function logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  task summarize;
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task chk(input logic [33:0] s, input logic [33:0] e);
    n_tests++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  // bready and rready stay high, which the bus allows
  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    int i;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (i == 50) begin
      error_cnt++;
      summarize();
    end else begin
      chk(34'(bresp), 34'(er));
    end
  endtask
  task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    araddr <= a;
    arvalid <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (i == 50) begin
      error_cnt++;
      summarize();
    end else begin
      d = rdata;
      r = rresp;
    end
  endtask
  initial begin
    logic [31:0] v[8], d;
    logic [5:0] offs[8];
    logic [7:0] wm[8], e1, segment_select_bits, sen, g6, m6, e6, x6;
    logic [3:0] sel, g9, e9, x9;
    logic [1:0] r;
    logic sb, hz;
    int k, j, ord[8];
    offs = '{LSG_OFF_P6_DATA, LSG_OFF_P6_DIR, LSG_OFF_P9_DATA, LSG_OFF_P9_DIR,
             LSG_OFF_LCD_EN1, LSG_OFF_LCD_EN3, LSG_OFF_LCD_EN4, LSG_OFF_STANDBY};
    wm = '{8'h00, 8'hff, 8'h00, 8'h0f, 8'hff, 8'hff, 8'hff, 8'hff};
    ord = '{0, 1, 2, 3, 5, 6, 4, 7};
    rs = 32'h1;
    error_cnt = 0;
    n_tests = 0;
    {aresetn, awvalid, wvalid, arvalid, standby_req} = 5'h00;
    {bready, rready} = 2'b11;
    {awaddr, araddr, wdata, wstrb, ext6, ext9} = '0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    for (k = 0; k < 10; k++) begin
      rd(6'(4 * k), d, r);
      chk({r, d}, {LSG_RESP_OKAY, 32'h0});
    end
    wr(6'h28, 32'hff, 4'hf, LSG_RESP_SLVERR);
    rd(6'h28, d, r);
    chk({r, d}, {LSG_RESP_SLVERR, 32'h0});
    wr(LSG_OFF_P6_DIR, 32'hff, 4'h0, LSG_RESP_OKAY);
    rd(LSG_OFF_P6_DIR, d, r);
    chk({r, d}, {LSG_RESP_OKAY, 32'h0});
    for (k = 0; k < 40; k++) begin
      x6 = 8'(rnd());
      x9 = 4'(rnd());
      sb = 1'(rnd());
      ext6 <= x6;
      ext9 <= x9;
      standby_req <= sb;
      for (j = 0; j < 8; j++) v[j] = rnd();
      // even passes keep the software duties, odd ones probe the driver lockout
      if (!k[0]) begin
        v[1][7:0] = v[1][7:0] & ~{v[6][5:0], v[5][7:6]};
        for (j = 0; j < 4; j++) v[3][j] = v[3][j] & ~v[4][4-j];
      end
      // segment selects land before input control and supply selects are written
      for (j = 0; j < 8; j++) begin
        wr(offs[ord[j]], v[ord[j]], 4'h1, LSG_RESP_OKAY);
      end
      for (j = 1; j < 8; j++) begin
        if (wm[j] != 8'h00) begin
          rd(offs[j], d, r);
          chk({r, d}, {LSG_RESP_OKAY, 24'h0, v[j][7:0] & wm[j]});
        end
      end
      e1 = v[4][7:0];
      segment_select_bits = {v[6][5:0], v[5][7:6]};
      sen = e1[0] ? segment_select_bits : 8'h00;
      hz = sb & v[7][0];
      for (j = 0; j < 4; j++) sel[j] = e1[4-j];
      g6 = hz ? 8'h00 : v[1][7:0] & ~segment_select_bits;
      g9 = hz ? 4'h0 : v[3][3:0] & ~sel;
      chk(34'(port6_pin_oe), 34'(hz ? 8'h00 : g6 | sen));
      chk(34'(port6_pin_o & g6), 34'(v[0][7:0] & g6));
      chk(34'(port9_pin_oe), 34'(g9));
      chk(34'(port9_pin_o & g9), 34'(v[2][3:0] & g9));
      chk(34'(lcd_seg_en), 34'(sen));
      chk(34'(lcd_supply_en), 34'(e1[4:1]));
      e6 = (v[1][7:0] & v[0][7:0]) | (~v[1][7:0] & ((hz | ~e1[0]) ? 8'h00 : x6));
      m6 = ~(segment_select_bits & ~v[1][7:0]);
      rd(LSG_OFF_P6_DATA, d, r);
      chk({r, d[31:8], d[7:0] & m6}, {LSG_RESP_OKAY, 24'h0, e6 & m6});
      e9 = (v[3][3:0] & v[2][3:0]) | (~v[3][3:0] & ~sel & (hz ? 4'h0 : x9));
      rd(LSG_OFF_P9_DATA, d, r);
      chk({r, d}, {LSG_RESP_OKAY, 28'h0, e9});
      rd(LSG_OFF_P6_LATCH, d, r);
      chk({r, d}, {LSG_RESP_OKAY, 24'h0, v[0][7:0]});
      rd(LSG_OFF_P9_LATCH, d, r);
      chk({r, d}, {LSG_RESP_OKAY, 28'h0, v[2][3:0]});
    end
    summarize();
  end
endmodule
`default_nettype wire
